// [hw/dtc_pkg.sv]
// Constants and types shared by the dual timer/counter
package dtc_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned PERIPH_NS = 480;
   localparam int unsigned PERIPH_CYC = (PERIPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DIV_W = 4;
   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] CTRL_ADDR = 8'h88;
   localparam logic [7:0] MODE_ADDR = 8'h89;
   localparam logic [7:0] TLA_ADDR = 8'h8a;
   localparam logic [7:0] TLB_ADDR = 8'h8b;
   localparam logic [7:0] THA_ADDR = 8'h8c;
   localparam logic [7:0] THB_ADDR = 8'h8d;
   ////////////////////////////////////////////////////////////////////////
   // Control/flag register bits
   localparam int unsigned B_OVF_BIT = 7;
   localparam int unsigned B_RUN_BIT = 6;
   localparam int unsigned A_OVF_BIT = 5;
   localparam int unsigned A_RUN_BIT = 4;
   localparam int unsigned IRQB_FLAG_BIT = 3;
   localparam int unsigned IRQB_EDGE_BIT = 2;
   localparam int unsigned IRQA_FLAG_BIT = 1;
   localparam int unsigned IRQA_EDGE_BIT = 0;
   ////////////////////////////////////////////////////////////////////////
   // Mode register fields
   localparam int unsigned B_GATE_BIT = 7;
   localparam int unsigned B_CLK_BIT = 6;
   localparam int unsigned B_MODE_LSB = 4;
   localparam int unsigned A_GATE_BIT = 3;
   localparam int unsigned A_CLK_BIT = 2;
   localparam int unsigned A_MODE_LSB = 0;
   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] CNT_RST = 8'h00;
   typedef enum logic [1:0] {
      DTC_MODE_13BIT = 2'b00,
      DTC_MODE_16BIT = 2'b01,
      DTC_MODE_RELOAD = 2'b10,
      DTC_MODE_SPLIT = 2'b11
   } dtc_mode_t;
endpackage : dtc_pkg

// [hw/dtc_sync.sv]
// Two-flop synchroniser for the external pins
`timescale 1ns/1ns
module dtc_sync #(
   parameter int unsigned W = 4,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Pins
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } dtc_sync_t;
   dtc_sync_t s_reg;
   dtc_sync_t s_next;

   if (W < 1)
   begin : g_bad_width
      $error("dtc_sync needs W >= 1");
   end

   always_comb
   begin
      s_next.stage1 = async_i;
      s_next.stage2 = s_reg.stage1;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         s_reg <= {RST_VAL, RST_VAL};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign sync_o = s_reg.stage2;
endmodule : dtc_sync

// [hw/dtc_timer_core.sv]
// Dual timer/counter with mode and control registers
// Function
// - Mode 1 chains low and high byte into one 16-bit up-counter.
// - Mode 2 low byte counts; overflow sets flag, reloads from high byte.
// - Overflow flag set on overflow, cleared when processor vectors to it.
// - Timer A mode 3 low byte uses timer A gate, select, run, flag.
// - Timer A mode 3 high byte counts divided clock on timer B run, B flag.
// - Timer B mode field 11 halts timer B and holds its count.
// - Timer B matches timer A in modes 0 to 2 with own controls.
// - Gate 0: run bit enables; gate 1: run and interrupt pin enable.
// - Clock select 0 counts divided clock; 1 counts count pin falling edges.
// - Mode field 00 13-bit, 01 16-bit, 10 auto-reload, 11 mode 3.
// - Mode register: B in upper nibble, A lower; gate, select, mode bits.
// - Control register resets to zero with fixed flag/run/irq layout.
// - Count wrap from all ones to zero sets the overflow flag.
// - Irq flag set on detection; edge mode clears it when processed.
// - Type 1 detects high-to-low edge; type 0 detects low level.
// - Timer operation increments once per twelve clock periods.
// - Count pin sampled once per peripheral cycle; high then low counts.
// - Mode 0 low five bits are a modulo-32 prescaler; upper three ignored.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module dtc_timer_core
   import dtc_pkg::*;
#(
   parameter int unsigned PERIPH_DIV = PERIPH_CYC
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // External pins
   input wire logic count_pin_a_i,
   input wire logic count_pin_b_i,
   input wire logic ext_irq_a_pin_n_i,
   input wire logic ext_irq_b_pin_n_i,
   // Interrupt vector acknowledges
   input wire logic tmr_a_vector_ack_i,
   input wire logic tmr_b_vector_ack_i,
   input wire logic irq_a_vector_ack_i,
   input wire logic irq_b_vector_ack_i,
   // Flags
   output logic timer_a_overflow_flag_o,
   output logic timer_b_overflow_flag_o,
   output logic ext_irq_a_flag_o,
   output logic ext_irq_b_flag_o
);
   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] timer_a_low_byte;
      logic [7:0] timer_a_high_byte;
      logic [7:0] timer_b_low_byte;
      logic [7:0] timer_b_high_byte;
      logic [1:0] cnt_samp;
      logic [1:0] irq_prev;
      logic [7:0] rdata;
   } dtc_state_t;

   dtc_state_t state_reg;
   dtc_state_t state_next;
   logic [3:0] pin_sync;
   logic tick;
   logic a_split;
   logic [1:0] mode_a;
   logic [1:0] mode_b;
   logic en_a;
   logic en_b;
   logic inc_a;
   logic inc_b;
   logic inc_ah;
   logic [16:0] res_a;
   logic [16:0] res_b;
   logic [8:0] sum_ah;
   logic set_a_ovf;
   logic set_b_ovf;
   logic [1:0] cnt_fall;
   logic [1:0] irq_fall;

   if (PERIPH_DIV < 2 || PERIPH_DIV > 2 ** DIV_W)
   begin : g_bad_div
      $error("PERIPH_DIV out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: count a, count b, irq a, irq b
   dtc_sync #(
      .W(4),
      .RST_VAL(4'hf)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .async_i({ext_irq_b_pin_n_i, ext_irq_a_pin_n_i, count_pin_b_i, count_pin_a_i}),
      .sync_o(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // One count step for a timer in the given mode; bit 16 is overflow
   function automatic logic [16:0] dtc_step(
      input logic [1:0] mode,
      input logic [7:0] hi,
      input logic [7:0] lo,
      input logic inc
   );
      logic [16:0] r;
      logic [8:0] s9;
      logic [5:0] p6;
      begin
         r = {1'b0, hi, lo};
         s9 = 9'h000;
         p6 = 6'h00;
         if (inc)
         begin
            case (mode)
               DTC_MODE_13BIT:
               begin
                  p6 = {1'b0, lo[4:0]} + 6'h01;
                  r[4:0] = p6[4:0];
                  if (p6[5])
                  begin
                     s9 = {1'b0, hi} + 9'h001;
                     r[15:8] = s9[7:0];
                     r[16] = s9[8];
                  end
               end
               DTC_MODE_16BIT:
               begin
                  r = {1'b0, hi, lo} + 17'h00001;
               end
               DTC_MODE_RELOAD:
               begin
                  if (lo == 8'hff)
                  begin
                     r[7:0] = hi;
                     r[16] = 1'b1;
                  end
                  else
                  begin
                     r[7:0] = lo + 8'h01;
                  end
               end
               default:
               begin
                  s9 = {1'b0, lo} + 9'h001;
                  r[7:0] = s9[7:0];
                  r[16] = s9[8];
               end
            endcase
         end
         return r;
      end
   endfunction : dtc_step

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      state_next = state_reg;
      state_next.rdata = 8'h00;
      tick = (state_reg.div == DIV_W'(PERIPH_DIV - 1));
      state_next.div = tick ? '0 : state_reg.div + DIV_W'(1);
      // Count pins sampled once per peripheral cycle
      cnt_fall = {2{tick}} & state_reg.cnt_samp & ~pin_sync[1:0];
      if (tick)
      begin
         state_next.cnt_samp = pin_sync[1:0];
      end
      irq_fall = state_reg.irq_prev & ~pin_sync[3:2];
      state_next.irq_prev = pin_sync[3:2];
      mode_a = state_reg.mode[A_MODE_LSB+:2];
      mode_b = state_reg.mode[B_MODE_LSB+:2];
      a_split = (mode_a == DTC_MODE_SPLIT);
      // Timer A
      en_a = state_reg.ctrl[A_RUN_BIT] & (~state_reg.mode[A_GATE_BIT] | pin_sync[2]);
      inc_a = en_a & (state_reg.mode[A_CLK_BIT] ? cnt_fall[0] : tick);
      res_a = dtc_step(mode_a, state_reg.timer_a_high_byte, state_reg.timer_a_low_byte, inc_a);
      state_next.timer_a_low_byte = res_a[7:0];
      state_next.timer_a_high_byte = res_a[15:8];
      // Split high byte counts the divided clock under timer B run
      inc_ah = a_split & tick & state_reg.ctrl[B_RUN_BIT];
      sum_ah = {1'b0, state_reg.timer_a_high_byte} + {8'h00, inc_ah};
      if (a_split)
      begin
         state_next.timer_a_high_byte = sum_ah[7:0];
      end
      // Timer B; run bit bypassed while timer A is split
      en_b = (a_split | state_reg.ctrl[B_RUN_BIT]) & (~state_reg.mode[B_GATE_BIT] | pin_sync[3]);
      inc_b = en_b & (mode_b != DTC_MODE_SPLIT) & (state_reg.mode[B_CLK_BIT] ? cnt_fall[1] : tick);
      res_b = dtc_step(mode_b, state_reg.timer_b_high_byte, state_reg.timer_b_low_byte, inc_b);
      state_next.timer_b_low_byte = res_b[7:0];
      state_next.timer_b_high_byte = res_b[15:8];
      set_a_ovf = res_a[16];
      set_b_ovf = a_split ? sum_ah[8] : res_b[16];
      // Software writes override the count in the same cycle
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            CTRL_ADDR: state_next.ctrl = reg_wdata_i;
            MODE_ADDR: state_next.mode = reg_wdata_i;
            TLA_ADDR: state_next.timer_a_low_byte = reg_wdata_i;
            TLB_ADDR: state_next.timer_b_low_byte = reg_wdata_i;
            THA_ADDR: state_next.timer_a_high_byte = reg_wdata_i;
            THB_ADDR: state_next.timer_b_high_byte = reg_wdata_i;
            default: state_next.ctrl = state_next.ctrl;
         endcase
      end
      // Vector acknowledges clear, hardware sets win
      if (tmr_a_vector_ack_i)
      begin
         state_next.ctrl[A_OVF_BIT] = 1'b0;
      end
      if (tmr_b_vector_ack_i)
      begin
         state_next.ctrl[B_OVF_BIT] = 1'b0;
      end
      if (irq_a_vector_ack_i && state_reg.ctrl[IRQA_EDGE_BIT])
      begin
         state_next.ctrl[IRQA_FLAG_BIT] = 1'b0;
      end
      if (irq_b_vector_ack_i && state_reg.ctrl[IRQB_EDGE_BIT])
      begin
         state_next.ctrl[IRQB_FLAG_BIT] = 1'b0;
      end
      if (set_a_ovf)
      begin
         state_next.ctrl[A_OVF_BIT] = 1'b1;
      end
      if (set_b_ovf)
      begin
         state_next.ctrl[B_OVF_BIT] = 1'b1;
      end
      // External interrupt detection: edge sets, level tracks the pin
      if (state_reg.ctrl[IRQA_EDGE_BIT])
      begin
         if (irq_fall[0])
         begin
            state_next.ctrl[IRQA_FLAG_BIT] = 1'b1;
         end
      end
      else
      begin
         state_next.ctrl[IRQA_FLAG_BIT] = ~pin_sync[2];
      end
      if (state_reg.ctrl[IRQB_EDGE_BIT])
      begin
         if (irq_fall[1])
         begin
            state_next.ctrl[IRQB_FLAG_BIT] = 1'b1;
         end
      end
      else
      begin
         state_next.ctrl[IRQB_FLAG_BIT] = ~pin_sync[3];
      end
      // Read data stand in the following cycle only
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            CTRL_ADDR: state_next.rdata = state_reg.ctrl;
            MODE_ADDR: state_next.rdata = state_reg.mode;
            TLA_ADDR: state_next.rdata = state_reg.timer_a_low_byte;
            TLB_ADDR: state_next.rdata = state_reg.timer_b_low_byte;
            THA_ADDR: state_next.rdata = state_reg.timer_a_high_byte;
            THB_ADDR: state_next.rdata = state_reg.timer_b_high_byte;
            default: state_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= '0;
         state_reg.ctrl <= CTRL_RST;
         state_reg.mode <= MODE_RST;
         state_reg.timer_a_low_byte <= CNT_RST;
         state_reg.timer_a_high_byte <= CNT_RST;
         state_reg.timer_b_low_byte <= CNT_RST;
         state_reg.timer_b_high_byte <= CNT_RST;
         state_reg.cnt_samp <= 2'h3;
         state_reg.irq_prev <= 2'h3;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign reg_rdata_o = state_reg.rdata;
   assign timer_a_overflow_flag_o = state_reg.ctrl[A_OVF_BIT];
   assign timer_b_overflow_flag_o = state_reg.ctrl[B_OVF_BIT];
   assign ext_irq_a_flag_o = state_reg.ctrl[IRQA_FLAG_BIT];
   assign ext_irq_b_flag_o = state_reg.ctrl[IRQB_FLAG_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking dtc_cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_ctrl_reset: assert property (disable iff (1'b0) !rst_n_i |=> state_reg.ctrl == 8'h00)
      else $error("control register not zero after reset");
   chk_tick_period: assert property (tick |-> ##12 tick)
      else $error("peripheral tick period wrong");
   chk_carry_chain: assert property (
      mode_a == DTC_MODE_16BIT && inc_a && state_reg.timer_a_low_byte == 8'hff && !reg_wr_i
      |=> state_reg.timer_a_high_byte == $past(state_reg.timer_a_high_byte) + 8'h01
         && state_reg.timer_a_low_byte == 8'h00)
      else $error("16-bit carry lost");
   chk_auto_reload: assert property (
      mode_b == DTC_MODE_RELOAD && !a_split && inc_b && state_reg.timer_b_low_byte == 8'hff && !reg_wr_i
      |=> state_reg.timer_b_low_byte == $past(state_reg.timer_b_high_byte) && state_reg.ctrl[B_OVF_BIT])
      else $error("auto-reload wrong");
   chk_ack_clear: assert property (
      tmr_a_vector_ack_i && !set_a_ovf && !reg_wr_i |=> !state_reg.ctrl[A_OVF_BIT])
      else $error("overflow flag not cleared on vector");
   chk_split_high: assert property (
      a_split && tick && state_reg.ctrl[B_RUN_BIT] && state_reg.timer_a_high_byte == 8'hff && !reg_wr_i
      |=> state_reg.ctrl[B_OVF_BIT] && state_reg.timer_a_high_byte == 8'h00)
      else $error("split high byte overflow missed");
   chk_halt_hold: assert property (
      (mode_b == DTC_MODE_SPLIT && !reg_wr_i) [*2]
      |-> $stable(state_reg.timer_b_low_byte) && $stable(state_reg.timer_b_high_byte))
      else $error("timer B moved while halted");
   chk_gate_stop: assert property (
      !a_split && state_reg.mode[A_GATE_BIT] && !pin_sync[2] && !reg_wr_i
      |=> state_reg.timer_a_low_byte == $past(state_reg.timer_a_low_byte))
      else $error("gated timer counted with pin low");
   chk_prescale_top: assert property (
      mode_b == DTC_MODE_13BIT && !reg_wr_i
      |=> state_reg.timer_b_low_byte[7:5] == $past(state_reg.timer_b_low_byte[7:5]))
      else $error("prescaler upper bits changed");
   chk_edge_detect: assert property (
      state_reg.ctrl[IRQA_EDGE_BIT] && irq_fall[0] |=> state_reg.ctrl[IRQA_FLAG_BIT])
      else $error("edge interrupt missed");
   chk_no_split_flag: assert property (
      a_split && !inc_ah && !reg_wr_i && !state_reg.ctrl[B_OVF_BIT] |=> !state_reg.ctrl[B_OVF_BIT])
      else $error("timer B flag set while timer A split");

   cov_reload: cover property (mode_a == DTC_MODE_RELOAD && set_a_ovf);
   cov_split: cover property (a_split && set_b_ovf);
   cov_edge_count: cover property (state_reg.mode[A_CLK_BIT] && inc_a);
endmodule : dtc_timer_core

// [sim/dtc_pin_model.sv]
// Far-side model: count pins, interrupt pins and processor vector acknowledges
`timescale 1ns/1ns
module dtc_pin_model
   import dtc_pkg::*;
(
   // Clock
   input wire logic core_clk_i,
   // Pins
   output logic count_pin_a_o,
   output logic count_pin_b_o,
   output logic ext_irq_a_pin_n_o,
   output logic ext_irq_b_pin_n_o,
   // Acknowledges: irq b, irq a, timer b, timer a
   output logic [3:0] ack_o
);
   initial
   begin
      count_pin_a_o = 1'b1;
      count_pin_b_o = 1'b1;
      ext_irq_a_pin_n_o = 1'b1;
      ext_irq_b_pin_n_o = 1'b1;
      ack_o = 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Both count pins pulse together; each level is held two peripheral cycles so every level is sampled
   task count_pulses(input int n);
      for (int i = 0; i < n; i++)
      begin
         count_pin_a_o <= 1'b0;
         count_pin_b_o <= 1'b0;
         repeat (2 * PERIPH_CYC) @(posedge core_clk_i);
         count_pin_a_o <= 1'b1;
         count_pin_b_o <= 1'b1;
         repeat (2 * PERIPH_CYC) @(posedge core_clk_i);
      end
   endtask : count_pulses
   task set_irq(input logic a, input logic b);
      ext_irq_a_pin_n_o <= a;
      ext_irq_b_pin_n_o <= b;
      repeat (4) @(posedge core_clk_i);
   endtask : set_irq
   task ack(input logic [3:0] v);
      ack_o <= v;
      @(posedge core_clk_i);
      ack_o <= 4'h0;
      repeat (2) @(posedge core_clk_i);
   endtask : ack
endmodule : dtc_pin_model

// [sim/dual_timer_counter_modes_tb_top.sv]
// Self-checking testbench for the dual timer/counter
`timescale 1ns/1ns
module dual_timer_counter_modes_tb_top
   import dtc_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic cpa, cpb, ipa_n, ipb_n;
   logic [3:0] ack;
   logic tfa, tfb, eia, eib;
   logic [1:0] fl;
   int error_cnt = 0;
   int tests_run = 0;
   always #20 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////
   dtc_timer_core #(.PERIPH_DIV(PERIPH_CYC)) dut_u (
      .core_clk_i(core_clk), .rst_n_i(rst_n),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata),
      .count_pin_a_i(cpa), .count_pin_b_i(cpb), .ext_irq_a_pin_n_i(ipa_n), .ext_irq_b_pin_n_i(ipb_n),
      .tmr_a_vector_ack_i(ack[0]), .tmr_b_vector_ack_i(ack[1]),
      .irq_a_vector_ack_i(ack[2]), .irq_b_vector_ack_i(ack[3]),
      .timer_a_overflow_flag_o(tfa), .timer_b_overflow_flag_o(tfb),
      .ext_irq_a_flag_o(eia), .ext_irq_b_flag_o(eib)
   );
   dtc_pin_model pins_u (
      .core_clk_i(core_clk), .count_pin_a_o(cpa), .count_pin_b_o(cpb),
      .ext_irq_a_pin_n_o(ipa_n), .ext_irq_b_pin_n_o(ipb_n), .ack_o(ack)
   );
   ////////////////////////////////////////////////////////////////////////
   task close_out;
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task rc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
      chk(d, exp);
   endtask : rc
   // Run bits stay set for exactly n peripheral cycles, so exactly n ticks land
   task run(input logic [7:0] on, input logic [7:0] off, input int n);
      wr(CTRL_ADDR, on);
      repeat (12 * n - 2) @(posedge core_clk);
      fl = {tfb, tfa};
      wr(CTRL_ADDR, off);
   endtask : run
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2000) @(posedge core_clk);
      error_cnt++;
      close_out();
   end
   initial
   begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rc(CTRL_ADDR, CTRL_RST);
      rc(MODE_ADDR, MODE_RST);
      wr(MODE_ADDR, 8'hd6);
      rc(MODE_ADDR, 8'hd6);
      wr(8'h90, 8'hff);
      rc(8'h90, 8'h00);
      rc(CTRL_ADDR, 8'h00);
      // Mode 1 on timer A, wrap of all ones
      wr(MODE_ADDR, 8'h01);
      wr(TLA_ADDR, 8'hfe);
      wr(THA_ADDR, 8'hff);
      run(8'h10, 8'h20, 3);
      chk({6'h00, fl}, 8'h01);
      rc(TLA_ADDR, 8'h01);
      rc(THA_ADDR, 8'h00);
      rc(CTRL_ADDR, 8'h20);
      pins_u.ack(4'h1);
      rc(CTRL_ADDR, 8'h00);
      // Mode 0 on timer B, prescaler carry
      wr(MODE_ADDR, 8'h00);
      wr(TLB_ADDR, 8'hfe);
      wr(THB_ADDR, 8'h10);
      run(8'h40, 8'h00, 3);
      rc(TLB_ADDR, 8'he1);
      rc(THB_ADDR, 8'h11);
      chk({6'h00, fl}, 8'h00);
      // Mode 2 on timer A, reload from high byte
      wr(MODE_ADDR, 8'h02);
      wr(TLA_ADDR, 8'hfe);
      wr(THA_ADDR, 8'h80);
      run(8'h10, 8'h00, 3);
      chk({6'h00, fl}, 8'h01);
      rc(TLA_ADDR, 8'h81);
      rc(THA_ADDR, 8'h80);
      // Mode 2 on timer B, same behaviour as timer A
      wr(MODE_ADDR, 8'h20);
      wr(TLB_ADDR, 8'hfe);
      wr(THB_ADDR, 8'h40);
      run(8'h40, 8'h00, 3);
      chk({6'h00, fl}, 8'h02);
      rc(TLB_ADDR, 8'h41);
      rc(THB_ADDR, 8'h40);
      // Counter operation on both timers
      wr(MODE_ADDR, 8'h55);
      wr(TLA_ADDR, 8'h00);
      wr(THA_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h50);
      pins_u.count_pulses(5);
      wr(CTRL_ADDR, 8'h00);
      rc(TLA_ADDR, 8'h05);
      rc(THA_ADDR, 8'h00);
      rc(TLB_ADDR, 8'h46);
      rc(THB_ADDR, 8'h40);
      // Gating by interrupt pin, level detection
      wr(MODE_ADDR, 8'h09);
      wr(TLA_ADDR, 8'h00);
      pins_u.set_irq(1'b0, 1'b1);
      chk({6'h00, eib, eia}, 8'h01);
      run(8'h10, 8'h00, 4);
      rc(TLA_ADDR, 8'h00);
      pins_u.set_irq(1'b1, 1'b1);
      run(8'h10, 8'h00, 4);
      rc(TLA_ADDR, 8'h04);
      // Timer A split, high byte on timer B run and flag
      wr(MODE_ADDR, 8'h23);
      wr(TLA_ADDR, 8'h00);
      wr(THA_ADDR, 8'hfe);
      run(8'h40, 8'h00, 3);
      chk({6'h00, fl}, 8'h02);
      rc(THA_ADDR, 8'h01);
      rc(TLA_ADDR, 8'h00);
      // Timer B keeps counting in split mode with run clear, and its overflow sets no flag
      wr(THB_ADDR, 8'h30);
      wr(TLB_ADDR, 8'hff);
      repeat (23) @(posedge core_clk);
      chk({7'h00, tfb}, 8'h00);
      rc(TLB_ADDR, 8'h31);
      wr(MODE_ADDR, 8'h33);
      wr(TLB_ADDR, 8'h55);
      repeat (48) @(posedge core_clk);
      rc(TLB_ADDR, 8'h55);
      // Edge detection on both interrupt pins
      wr(CTRL_ADDR, 8'h05);
      pins_u.set_irq(1'b0, 1'b0);
      chk({6'h00, eib, eia}, 8'h03);
      pins_u.set_irq(1'b1, 1'b1);
      chk({6'h00, eib, eia}, 8'h03);
      pins_u.ack(4'h8);
      chk({6'h00, eib, eia}, 8'h01);
      pins_u.ack(4'h4);
      chk({6'h00, eib, eia}, 8'h00);
      close_out();
   end
endmodule : dual_timer_counter_modes_tb_top
